// File: logic/cbrw_core.v
// Purpose: parses block read and write commands and builds their responses
// Assumes: command bytes arrive framed, last byte flagged by rx_last
// Notes: responses leave through an eight entry fifo; tunnel mode uses host ports
//
// Operation
// (RQ1) read request: code 06, 8-byte id, k, 2k service bytes, m, block list.
// (RQ2) reader fills the id field with the identifier it learned earlier.
// (RQ3) read accepts service count 1 to 15, otherwise error status.
// (RQ4) service ids ignored, but multiple ones must all be equal.
// (RQ5) read accepts block count 1 to 15, otherwise error status.
// (RQ6) read answer: 07, id, two flags; count and data only on normal end.
// (RQ7) successful read answer repeats the requested block count.
// (RQ8) write request: code 08, same leading fields, then 16 bytes per block.
// (RQ9) write accepts service count 1 to 11, otherwise error status.
// (RQ10) write block limit: 12 with up to 8 services, 11 with 9 to 11.
// (RQ11) write stores data or forwards to host, answers 09, id, two flags.
// (RQ12) attribute information block sits at user block 0.
// (RQ13) message file occupies user blocks 1 through 23.
// (RQ14) bad service count reports flags FF A1.
// (RQ15) bad block count reports flags FF A2.
// (RQ16) unequal service ids report flags FF A3.
// (RQ17) non-ascending block numbers in tunnel mode report flags FF A5.
// (RQ18) each list element's header decides two or three bytes before advancing.
`timescale 1ns/1ps
`include "cbrw_consts.vh"
module cbrw_core (
    input wire clk,
    input wire rst,
    input wire tunnel_en,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_last,
    output wire rx_ready,
    output wire tx_valid,
    output wire [7:0] tx_data,
    output wire tx_last,
    input wire tx_ready,
    output reg tun_wr_valid,
    output reg [7:0] tun_wr_data,
    input wire tun_wr_ready,
    input wire tun_rd_valid,
    input wire [7:0] tun_rd_data,
    output wire tun_rd_ready,
    output wire busy
);
    // one-hot parser states
    localparam S_CODE = 9'h001;
    localparam S_ID = 9'h002;
    localparam S_SVCN = 9'h004;
    localparam S_SVC = 9'h008;
    localparam S_BLKN = 9'h010;
    localparam S_BLK = 9'h020;
    localparam S_DATA = 9'h040;
    localparam S_SKIP = 9'h080;
    localparam S_RESP = 9'h100;

    reg [8:0] state;
    reg [7:0] cnt;
    reg is_wr;
    reg tun;
    reg [7:0] card_id [0:7];
    reg [7:0] svc_n;
    reg [7:0] blk_n;
    reg [7:0] svc_first [0:1];
    reg svc_mix;
    reg [7:0] err;
    reg [3:0] blk_idx;
    reg [1:0] epos;
    reg elem_long;
    reg elem_bad;
    reg [7:0] elem_lo;
    reg list_bad;
    reg have_prev;
    reg [7:0] prev_num;
    reg [7:0] blk_num [0:14];
    reg [7:0] mem [0:`CBRW_MEM_BYTES-1];
    reg [7:0] ridx;
    reg [3:0] rblk;
    reg [3:0] rbyte;

    wire take;
    wire svc_ok;
    wire blk_ok;
    wire [7:0] blk_max_wr;
    wire [7:0] elem_num;
    wire elem_done;
    wire list_end;
    wire data_phase;
    wire resp_push;
    wire resp_last;
    wire fifo_in_ready;
    wire [8:0] wr_addr;
    wire [8:0] rd_addr;
    reg [7:0] resp_byte;

    // tunnel write holds a byte until the host takes it; this stalls intake
    assign rx_ready = (state != S_RESP) &&
        !(state == S_DATA && tun && tun_wr_valid && !tun_wr_ready);
    assign take = rx_valid && rx_ready;
    assign busy = (state != S_CODE);

    // count ranges per command
    assign svc_ok = (rx_data >= `CBRW_CNT_MIN) &&
        (rx_data <= (is_wr ? `CBRW_WR_SVC_MAX : `CBRW_RD_SVC_MAX)); // [RQ3] [RQ9]
    assign blk_max_wr = (svc_n <= `CBRW_WR_SVC_SPLIT) ?
        `CBRW_WR_BLK_MAX_LO : `CBRW_WR_BLK_MAX_HI; // [RQ10]
    assign blk_ok = (rx_data >= `CBRW_CNT_MIN) &&
        (rx_data <= (is_wr ? blk_max_wr : `CBRW_RD_BLK_MAX)); // [RQ5] [RQ10]

    // element length known from its first byte: bit 7 set means two bytes
    assign elem_done = (epos == 2'd1 && !elem_long) || (epos == 2'd2); // [RQ18]
    assign elem_num = (epos == 2'd1) ? rx_data : elem_lo;
    assign list_end = elem_done && ({4'h0, blk_idx} == blk_n - 8'h01);

    // block numbers index user memory: block 0 is the attribute block,
    // blocks 1 to 23 the message file; anything above is out of memory
    assign wr_addr = {blk_num[blk_idx][4:0], cnt[3:0]}; // [RQ12] [RQ13]
    assign rd_addr = {blk_num[rblk][4:0], rbyte}; // [RQ12] [RQ13]

    // response data bytes follow only a clean read
    assign data_phase = (ridx == 8'd12);
    assign resp_last = data_phase ? (rblk == blk_n[3:0] - 4'h1 && rbyte == 4'hF) :
        (ridx == 8'd11 ? 1'b0 : (ridx == 8'd10 && (is_wr || err != `CBRW_SF_OK))); // [RQ6]
    assign resp_push = (state == S_RESP) && (!data_phase || !tun || tun_rd_valid);
    assign tun_rd_ready = (state == S_RESP) && data_phase && tun && fifo_in_ready;

    // response byte selection
    always @* begin
        resp_byte = 8'h00;
        if (ridx == 8'd0) begin
            resp_byte = is_wr ? `CBRW_RSP_WRITE : `CBRW_RSP_READ; // [RQ6] [RQ11]
        end else if (ridx <= 8'd8) begin
            resp_byte = card_id[ridx[2:0] - 3'd1];
        end else if (ridx == 8'd9) begin
            resp_byte = (err == `CBRW_SF_OK) ? `CBRW_SF_OK : `CBRW_SF1_ERR;
        end else if (ridx == 8'd10) begin
            resp_byte = err;
        end else if (ridx == 8'd11) begin
            resp_byte = blk_n; // [RQ7]
        end else begin
            resp_byte = tun ? tun_rd_data : mem[rd_addr];
        end
    end

    // user memory written by accepted write data outside tunnel mode
    always @(posedge clk) begin
        if (state == S_DATA && take && !tun) begin
            mem[wr_addr] <= rx_data; // [RQ11]
        end
    end

    // identifier and block list capture, no reset needed for data words
    always @(posedge clk) begin
        if (state == S_ID && take) begin
            card_id[cnt[2:0]] <= rx_data; // [RQ1]
        end
        if (state == S_SVC && take && cnt < 8'd2) begin
            svc_first[cnt[0]] <= rx_data;
        end
        if (state == S_BLK && take && elem_done) begin
            blk_num[blk_idx] <= elem_num;
        end
    end

    // tunnel write byte holding stage toward the host
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tun_wr_valid <= 1'b0;
            tun_wr_data <= 8'h00;
        end else begin
            if (state == S_DATA && take && tun) begin
                tun_wr_valid <= 1'b1; // [RQ11]
                tun_wr_data <= rx_data;
            end else if (tun_wr_ready) begin
                tun_wr_valid <= 1'b0;
            end
        end
    end

    // command parser and response sequencer
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= S_CODE;
            cnt <= 8'h00;
            is_wr <= 1'b0;
            tun <= 1'b0;
            svc_n <= 8'h00;
            blk_n <= 8'h00;
            svc_mix <= 1'b0;
            err <= 8'h00;
            blk_idx <= 4'h0;
            epos <= 2'd0;
            elem_long <= 1'b0;
            elem_bad <= 1'b0;
            elem_lo <= 8'h00;
            list_bad <= 1'b0;
            have_prev <= 1'b0;
            prev_num <= 8'h00;
            ridx <= 8'h00;
            rblk <= 4'h0;
            rbyte <= 4'h0;
        end else begin
            case (state)
            S_CODE: begin
                if (take) begin
                    cnt <= 8'h00;
                    err <= `CBRW_SF_OK;
                    svc_mix <= 1'b0;
                    list_bad <= 1'b0;
                    have_prev <= 1'b0;
                    blk_idx <= 4'h0;
                    epos <= 2'd0;
                    tun <= tunnel_en;
                    is_wr <= (rx_data == `CBRW_CMD_WRITE); // [RQ8]
                    // unknown codes and lone bytes are dropped silently
                    if (!rx_last && (rx_data == `CBRW_CMD_READ ||
                            rx_data == `CBRW_CMD_WRITE)) begin
                        state <= S_ID; // [RQ1]
                    end
                end
            end
            S_ID: begin
                if (take) begin
                    cnt <= cnt + 8'h01;
                    if (rx_last) begin
                        state <= S_CODE;
                    end else if (cnt == `CBRW_ID_LEN - 8'h01) begin
                        state <= S_SVCN;
                    end
                end
            end
            S_SVCN: begin
                if (take) begin
                    svc_n <= rx_data;
                    cnt <= 8'h00;
                    if (!svc_ok) begin
                        err <= `CBRW_SF2_SVC_CNT; // [RQ14]
                        state <= rx_last ? S_RESP : S_SKIP;
                    end else if (rx_last) begin
                        state <= S_CODE;
                    end else begin
                        state <= S_SVC;
                    end
                end
            end
            S_SVC: begin
                if (take) begin
                    cnt <= cnt + 8'h01;
                    // value itself is ignored, only agreement counts
                    if (cnt >= 8'd2 && rx_data != svc_first[cnt[0]]) begin
                        svc_mix <= 1'b1; // [RQ4]
                    end
                    if (rx_last) begin
                        state <= S_CODE;
                    end else if (cnt == {svc_n[6:0], 1'b0} - 8'h01) begin
                        state <= S_BLKN;
                    end
                end
            end
            S_BLKN: begin
                if (take) begin
                    blk_n <= rx_data;
                    if (svc_mix) begin
                        err <= `CBRW_SF2_SVC_MIX; // [RQ16]
                        state <= rx_last ? S_RESP : S_SKIP;
                    end else if (!blk_ok) begin
                        err <= `CBRW_SF2_BLK_CNT; // [RQ15]
                        state <= rx_last ? S_RESP : S_SKIP;
                    end else if (rx_last) begin
                        state <= S_CODE;
                    end else begin
                        state <= S_BLK;
                    end
                end
            end
            S_BLK: begin
                if (take) begin
                    if (epos == 2'd0) begin
                        elem_long <= !rx_data[7]; // [RQ18]
                        elem_bad <= (rx_data[6:4] != 3'b000);
                        epos <= 2'd1;
                    end else if (epos == 2'd1 && elem_long) begin
                        elem_lo <= rx_data;
                        epos <= 2'd2;
                    end else begin
                        epos <= 2'd0;
                    end
                    if (elem_done) begin
                        blk_idx <= blk_idx + 4'h1;
                        have_prev <= 1'b1;
                        prev_num <= elem_num;
                        // mode bits, high number byte, memory bound, ordering
                        if (elem_bad || (epos == 2'd2 && rx_data != 8'h00) ||
                                (!tun && elem_num > `CBRW_NDEF_LAST) ||
                                (tun && have_prev && elem_num <= prev_num)) begin
                            list_bad <= 1'b1; // [RQ17]
                        end
                    end
                    if (list_end) begin
                        blk_idx <= 4'h0;
                        cnt <= 8'h00;
                        if (list_bad || elem_bad || (epos == 2'd2 && rx_data != 8'h00) ||
                                (!tun && elem_num > `CBRW_NDEF_LAST) ||
                                (tun && have_prev && elem_num <= prev_num)) begin
                            err <= `CBRW_SF2_BLK_SPEC; // [RQ17]
                            state <= rx_last ? S_RESP : S_SKIP;
                        end else if (!is_wr) begin
                            state <= rx_last ? S_RESP : S_SKIP;
                        end else begin
                            state <= rx_last ? S_CODE : S_DATA; // [RQ8]
                        end
                    end else if (rx_last) begin
                        state <= S_CODE;
                    end
                end
            end
            S_DATA: begin
                if (take) begin
                    cnt <= cnt + 8'h01;
                    if (cnt[3:0] == 4'hF) begin
                        cnt <= 8'h00;
                        blk_idx <= blk_idx + 4'h1;
                    end
                    if (cnt[3:0] == 4'hF && {4'h0, blk_idx} == blk_n - 8'h01) begin
                        state <= S_RESP; // [RQ11]
                    end else if (rx_last) begin
                        state <= S_CODE;
                    end
                end
            end
            S_SKIP: begin
                // trailing bytes after a decision are drained to the frame end
                if (take && rx_last) begin
                    state <= S_RESP;
                end
            end
            S_RESP: begin
                if (resp_push && fifo_in_ready) begin
                    if (resp_last) begin
                        state <= S_CODE;
                        ridx <= 8'h00;
                        rblk <= 4'h0;
                        rbyte <= 4'h0;
                    end else if (!data_phase) begin
                        ridx <= ridx + 8'h01;
                    end else begin
                        rbyte <= rbyte + 4'h1;
                        if (rbyte == 4'hF) begin
                            rblk <= rblk + 4'h1;
                        end
                    end
                end
            end
            default: begin
                state <= S_CODE;
            end
            endcase
        end
    end

    // outgoing response bytes buffered; tx_ready stalls the sequencer
    cbrw_fifo #(
        .WIDTH(9),
        .DEPTH(`CBRW_FIFO_DEPTH),
        .AW(`CBRW_FIFO_AW)
    ) cbrw_fifo_i (
        .clk(clk),
        .rst(rst),
        .in_valid(resp_push),
        .in_ready(fifo_in_ready),
        .in_data({resp_last, resp_byte}),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data({tx_last, tx_data})
    );
endmodule

// File: inc/cbrw_consts.vh
// Purpose: shared constants of the contactless block read/write interpreter
// Assumes: included by bare name from logic files
// Notes: codes, status flags, count limits and memory layout
`ifndef CBRW_CONSTS_VH
`define CBRW_CONSTS_VH

// command and response codes
`define CBRW_CMD_READ 8'h06
`define CBRW_RSP_READ 8'h07
`define CBRW_CMD_WRITE 8'h08
`define CBRW_RSP_WRITE 8'h09

// field lengths in bytes
`define CBRW_ID_LEN 8'h08
`define CBRW_BLK_BYTES 8'h10

// status flag values
`define CBRW_SF_OK 8'h00
`define CBRW_SF1_ERR 8'hFF
`define CBRW_SF2_SVC_CNT 8'hA1
`define CBRW_SF2_BLK_CNT 8'hA2
`define CBRW_SF2_SVC_MIX 8'hA3
`define CBRW_SF2_BLK_SPEC 8'hA5

// count limits
`define CBRW_CNT_MIN 8'h01
`define CBRW_RD_SVC_MAX 8'h0F
`define CBRW_RD_BLK_MAX 8'h0F
`define CBRW_WR_SVC_MAX 8'h0B
`define CBRW_WR_SVC_SPLIT 8'h08
`define CBRW_WR_BLK_MAX_LO 8'h0C
`define CBRW_WR_BLK_MAX_HI 8'h0B

// user memory layout: attribute block then message file
`define CBRW_AIB_BLOCK 8'h00
`define CBRW_NDEF_FIRST 8'h01
`define CBRW_NDEF_LAST 8'h17
`define CBRW_MEM_BYTES 384

// response fifo
`define CBRW_FIFO_DEPTH 8
`define CBRW_FIFO_AW 3

`endif

// File: logic/cbrw_fifo.v
// Purpose: synchronous fifo carrying response bytes with their end marker
// Assumes: one clock, asynchronous active high reset
// Notes: DEPTH must equal 2**AW; full and empty follow the fill count
`timescale 1ns/1ps
module cbrw_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] fill;
    wire push;
    wire pop;

    // honest flags straight from the fill count
    assign in_ready = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign out_data = store[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage has no reset; only pointers and the fill count carry state
    always @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    // pointer and count update
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            fill <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule

// File: bench/cbrw_monitor.sv
// Purpose: port checks on the block read/write interpreter
// Assumes: one clock, asynchronous active high reset
// Notes: response bytes counted from the code byte
`timescale 1ns/1ps
module cbrw_monitor (
    input logic clk,
    input logic rst,
    input logic tunnel_en,
    input logic rx_valid,
    input logic [7:0] rx_data,
    input logic rx_last,
    input logic rx_ready,
    input logic tx_valid,
    input logic [7:0] tx_data,
    input logic tx_last,
    input logic tx_ready,
    input logic tun_wr_valid,
    input logic [7:0] tun_wr_data,
    input logic tun_wr_ready,
    input logic tun_rd_valid,
    input logic [7:0] tun_rd_data,
    input logic tun_rd_ready,
    input logic busy
);
    logic fire;
    logic [8:0] idx;
    logic [7:0] rc;
    logic [7:0] sf1;
    logic [7:0] mc;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    assign fire = tx_valid && tx_ready;
    // byte index in a response and the fields later bytes depend on
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            idx <= 9'h000;
            rc <= 8'h00;
            sf1 <= 8'h00;
            mc <= 8'h00;
        end else if (fire) begin
            idx <= tx_last ? 9'h000 : idx + 9'h001;
            if (idx == 9'h000) rc <= tx_data;
            if (idx == 9'h009) sf1 <= tx_data;
            if (idx == 9'h00B) mc <= tx_data;
        end
    end
    property p_tx_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("byte changed while stalled");
    property p_rsp_code;
        fire && idx == 9'h000 |-> tx_data == 8'h07 || tx_data == 8'h09;
    endproperty
    a_rsp_code: assert property (p_rsp_code) else $error("bad response code");
    property p_sf1;
        fire && idx == 9'h009 |-> tx_data == 8'h00 || tx_data == 8'hFF;
    endproperty
    a_sf1: assert property (p_sf1) else $error("bad first status flag");
    property p_err_end;
        fire && idx == 9'h00A && sf1 == 8'hFF |-> tx_last && tx_data inside {8'hA1, 8'hA2, 8'hA3, 8'hA5};
    endproperty
    a_err_end: assert property (p_err_end) else $error("bad error ending");
    property p_wr_end;
        fire && idx == 9'h00A && rc == 8'h09 |-> tx_last;
    endproperty
    a_wr_end: assert property (p_wr_end) else $error("write answer too long");
    property p_rd_cnt;
        fire && idx == 9'h00B |-> tx_data >= 8'h01 && tx_data <= 8'h0F;
    endproperty
    a_rd_cnt: assert property (p_rd_cnt) else $error("read count out of range");
    property p_rd_end;
        fire && idx > 9'h00B && rc == 8'h07 && sf1 == 8'h00
            |-> tx_last == (idx == 9'h00B + {1'b0, mc[3:0], 4'h0});
    endproperty
    a_rd_end: assert property (p_rd_end) else $error("read length wrong");
    property p_tun_hold;
        tun_wr_valid && !tun_wr_ready |=> tun_wr_valid && $stable(tun_wr_data);
    endproperty
    a_tun_hold: assert property (p_tun_hold) else $error("host byte dropped");
    property p_idle_ready;
        !busy && rx_valid && rx_ready && rx_last |=> !busy;
    endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("foreign code left idle");
    c_err: cover property (fire && idx == 9'h00A && sf1 == 8'hFF);
    c_rd_ok: cover property (fire && idx == 9'h00B);
    c_tun: cover property (tun_wr_valid && tun_wr_ready);
endmodule

bind cbrw_core cbrw_monitor cbrw_monitor_i (.clk, .rst, .tunnel_en, .rx_valid, .rx_data,
    .rx_last, .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_ready, .tun_wr_valid,
    .tun_wr_data, .tun_wr_ready, .tun_rd_valid, .tun_rd_data, .tun_rd_ready, .busy);

// File: bench/cbrw_reader.sv
// Purpose: reader model sending command frames and taking answers
// Assumes: drives on the falling clock edge
// Notes: stall holds tx_ready low so the answer fifo backs up
`timescale 1ns/1ps
module cbrw_reader (
    input logic clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    input logic rx_ready,
    input logic tx_valid,
    input logic [7:0] tx_data,
    input logic tx_last,
    output logic tx_ready
);
    logic [8:0] rq[$];
    int stall = 0;
    bit to = 0;
    initial begin
        rx_valid = 0;
        rx_data = 8'h00;
        rx_last = 0;
        tx_ready = 1;
    end
    // each byte held until taken; idle data inverted so no stale byte repeats
    task automatic send(input logic [7:0] f[$]);
        int n;
        foreach (f[i]) begin
            @(negedge clk);
            rx_valid = 1;
            rx_data = f[i];
            rx_last = (i == f.size() - 1);
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (!rx_ready && n < 2000);
            if (n >= 2000) to = 1;
        end
        @(negedge clk);
        rx_valid = 0;
        rx_last = 0;
        rx_data = ~rx_data;
    endtask
    // collect answer bytes with their end mark
    always @(posedge clk)
        if (tx_valid && tx_ready) rq.push_back({tx_last, tx_data});
    // stall countdown
    always @(negedge clk) begin
        tx_ready <= (stall == 0);
        if (stall > 0) stall <= stall - 1;
    end
endmodule

// File: bench/cbrw_core_tb_top.sv
// Purpose: self-checking bench for the block read/write interpreter
// Assumes: reader model on the command side, host modelled here
// Notes: memory is not reset, so only written blocks are compared
`timescale 1ns/1ps
`include "cbrw_consts.vh"
module cbrw_core_tb_top;
    typedef struct {logic [7:0] c; int k; bit x; int m; logic [7:0] b; logic [7:0] s;} cbrw_case_t;
    logic clk = 0;
    logic rst = 1;
    logic tunnel_en = 0;
    logic tun_wr_ready = 0;
    logic [7:0] tun_rd_data = 8'h40;
    logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
    logic tun_wr_valid, tun_rd_ready, busy;
    logic [7:0] rx_data, tx_data, tun_wr_data;
    logic [7:0] fr[$], bl[$], tq[$];
    int n_mismatch = 0, n_checks = 0, nrd = 0;
    always #50 clk = ~clk;
    cbrw_core cbrw_core_i (.clk, .rst, .tunnel_en, .rx_valid, .rx_data, .rx_last, .rx_ready,
        .tx_valid, .tx_data, .tx_last, .tx_ready, .tun_wr_valid, .tun_wr_data, .tun_wr_ready,
        .tun_rd_valid(tun_wr_ready), .tun_rd_data, .tun_rd_ready, .busy);
    cbrw_reader cbrw_reader_i (.clk, .rx_valid, .rx_data, .rx_last, .rx_ready, .tx_valid,
        .tx_data, .tx_last, .tx_ready);
    // host end: takes and offers every other cycle, counting bytes
    always @(posedge clk) begin
        if (tun_wr_valid && tun_wr_ready) tq.push_back(tun_wr_data);
        if (tun_rd_ready && tun_wr_ready) nrd++;
    end
    always @(negedge clk) begin
        tun_wr_ready <= ~tun_wr_ready;
        tun_rd_data <= 8'h40 + nrd[7:0];
    end
    function automatic logic [7:0] pat(logic [7:0] b, int j);
        return {b[3:0], 4'(j)} ^ 8'hC3;
    endfunction
    task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // frame builder; element 1 takes the three byte form, write data follows
    task automatic mk(logic [7:0] c, int k, bit x, int m, logic [7:0] b, int st);
        fr = {c};
        bl = {};
        for (int i = 0; i < 8; i++) fr.push_back(8'hD0 + 8'(i));
        fr.push_back(8'(k));
        for (int i = 0; i < k; i++) fr = {fr, 8'h09, (x && i == k - 1) ? 8'h01 : 8'h00};
        fr.push_back(8'(m));
        for (int i = 0; i < m; i++) begin
            bl.push_back(b + 8'(i * st));
            if (i == 1) fr = {fr, 8'h00, bl[i], 8'h00};
            else fr = {fr, 8'h80, bl[i]};
        end
        if (c == `CBRW_CMD_WRITE)
            foreach (bl[i]) for (int j = 0; j < 16; j++) fr.push_back(pat(bl[i], j));
    endtask
    // send, await the answer, compare fields; dm picks the data source
    task automatic run(logic [7:0] rc, logic [7:0] s, int dm, logic [7:0] hb);
        int n;
        logic [8:0] r[$];
        logic [7:0] e;
        cbrw_reader_i.rq = {};
        cbrw_reader_i.send(fr);
        n = 0;
        while (!(cbrw_reader_i.rq.size() > 0 && cbrw_reader_i.rq[$][8]) && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000 || cbrw_reader_i.to) begin
            n_mismatch++;
            results();
        end
        r = cbrw_reader_i.rq;
        chk("code", r[0][7:0], rc);
        for (int i = 0; i < 8; i++) chk("id", r[1 + i][7:0], fr[1 + i]);
        chk("flag1", r[9][7:0], (s == 8'h00) ? 8'h00 : `CBRW_SF1_ERR);
        chk("flag2", r[10][7:0], s);
        e = (rc == `CBRW_RSP_READ && s == 8'h00) ? 8'(12 + 16 * bl.size()) : 8'h0B;
        chk("length", 8'(r.size()), e);
        if (r.size() > 11) chk("count", r[11][7:0], 8'(bl.size()));
        if (dm > 0)
            foreach (bl[i]) for (int j = 0; j < 16; j++) begin
                e = (dm == 1) ? pat(bl[i], j) : hb + 8'(16 * i + j);
                chk("data", r[12 + 16 * i + j][7:0], e);
            end
    endtask
    // attribute block and last message block, read back with the answer stalled
    task automatic t_mem();
        mk(`CBRW_CMD_WRITE, 1, 0, 2, `CBRW_AIB_BLOCK, 23);
        run(`CBRW_RSP_WRITE, `CBRW_SF_OK, 0, 0);
        mk(`CBRW_CMD_READ, 1, 0, 2, 8'h00, 23);
        cbrw_reader_i.stall = 60;
        run(`CBRW_RSP_READ, `CBRW_SF_OK, 1, 0);
        $display("test mem done");
    endtask
    // count limits at both edges, error priority, mixed services, block past memory
    task automatic t_lim();
        cbrw_case_t t[13] = '{
            '{8'h06, 0, 0, 0, 8'h00, 8'hA1}, '{8'h06, 16, 0, 1, 8'h00, 8'hA1},
            '{8'h08, 12, 0, 1, 8'h00, 8'hA1}, '{8'h06, 2, 1, 16, 8'h00, 8'hA3},
            '{8'h06, 1, 0, 0, 8'h00, 8'hA2}, '{8'h06, 1, 0, 16, 8'h00, 8'hA2},
            '{8'h08, 9, 0, 12, 8'h00, 8'hA2}, '{8'h08, 1, 0, 13, 8'h00, 8'hA2},
            '{8'h08, 8, 0, 12, 8'h00, 8'h00}, '{8'h08, 9, 0, 11, 8'h00, 8'h00},
            '{8'h08, 11, 0, 1, 8'h00, 8'h00}, '{8'h06, 15, 0, 15, 8'h00, 8'h00},
            '{8'h06, 1, 0, 1, 8'h18, 8'hA5}};
        foreach (t[i]) begin
            mk(t[i].c, t[i].k, t[i].x, t[i].m, t[i].b, 1);
            run(t[i].c + 8'h01, t[i].s, 0, 0);
        end
        mk(8'h0A, 1, 0, 1, 8'h00, 1);
        cbrw_reader_i.rq = {};
        cbrw_reader_i.send(fr);
        repeat (20) @(posedge clk);
        chk("dropped", 8'(cbrw_reader_i.rq.size()), 8'h00);
        $display("test limits done");
    endtask
    // tunnel write and read via the host, then block order with and without tunnel
    task automatic t_tun();
        @(negedge clk);
        tunnel_en = 1;
        tq = {};
        mk(`CBRW_CMD_WRITE, 1, 0, 1, 8'h05, 1);
        run(`CBRW_RSP_WRITE, `CBRW_SF_OK, 0, 0);
        chk("host count", 8'(tq.size()), 8'h10);
        for (int j = 0; j < 16; j++) chk("host byte", tq[j], pat(8'h05, j));
        mk(`CBRW_CMD_READ, 1, 0, 1, 8'h03, 1);
        run(`CBRW_RSP_READ, `CBRW_SF_OK, 2, 8'h40 + 8'(nrd));
        mk(`CBRW_CMD_READ, 1, 0, 2, 8'h05, -2);
        run(`CBRW_RSP_READ, `CBRW_SF2_BLK_SPEC, 0, 0);
        @(negedge clk);
        tunnel_en = 0;
        mk(`CBRW_CMD_READ, 1, 0, 2, 8'h17, -23);
        run(`CBRW_RSP_READ, `CBRW_SF_OK, 1, 0);
        $display("test tunnel done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 0;
        t_mem();
        t_lim();
        t_tun();
        results();
    end
endmodule
